// File: chg_axis_map.vh
// constants for the speed/position changeover axis controller
//
// Notes on behaviour
// - switch speed to position control only on changeover input during such a run.
// - enable must be on before input; enable rising after input keeps speed control.
// - enable and input both on at start: skip speed phase, position only.
// - in-speed-control status stays on throughout the speed phase.
// - policy 0: feed value frozen in speed phase, updates from changeover.
// - policy 1: feed value updates in both phases.
// - policy 2: feed value cleared at start, updates from changeover.
// - changeover latch status sets 1 ms after changeover input turns on.
// - movement change accepted only in speed phase; otherwise ignored.
// - amount written in speed phase becomes position travel at changeover.
// - position-phase amount shown on monitor from the changeover onward.
// - any write to the movement-change word is a change request.
// - absolute-target mode ignores movement-change writes.
// - continuous-path pattern at start: refuse start, error 516.
// - previous data continuous path then changeover data: error 516, decel stop.
// - stroke check in speed phase for policy 1, non-degree; error 507/508.
// - incremental amount below decel distance: decelerate at changeover.
// - incremental changeover while accelerating raises warning 508.
// - speed phase keeps pulsing at command speed until stop or changeover.
// - incremental: move programmed amount from the switch point.
// - absolute-target mode (degree only): position to programmed address.
`ifndef CHG_AXIS_MAP_VH
`define CHG_AXIS_MAP_VH
// 1 ms at the 50 MHz clock, sized to the latch counter width
`define LATCH_CYCLES 16'hc350
`define LATCH_CNT_W 16
`define POLICY_FREEZE 2'h0
`define POLICY_UPDATE 2'h1
`define POLICY_ZERO 2'h2
`define UNIT_DEGREE 2'h2
`define PATTERN_CONT_PATH 2'h2
`define ERR_NONE 16'h0000
`define ERR_CONT_PATH 16'h0204
`define ERR_STROKE_HI 16'h01fb
`define ERR_STROKE_LO 16'h01fc
`define WARN_NONE 16'h0000
`define WARN_ACCEL 16'h01fc
`define PH_IDLE 3'h0
`define PH_SPEED 3'h1
`define PH_POS 3'h2
`define PH_DECEL 3'h3
`define PH_DONE 3'h4
`endif

// File: chg_input_sync.v
// three-stage synchroniser with agreement check for the changeover pin
`default_nettype none
module chg_input_sync (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire pin,
  output reg level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // ------------------------------------------------------------
  // stages: first flop read only by the second
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level <= 1'b0;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change counts once stages two and three agree
      if (s2_q == s3_q)
        level <= s3_q;
    end
  end
endmodule
`default_nettype wire

// File: chg_latch_timer.v
// delay timer: raises done a fixed count after start
`include "chg_axis_map.vh"
`default_nettype none
module chg_latch_timer #(
  parameter [`LATCH_CNT_W-1:0] CYCLES = `LATCH_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire clear,
  input wire start,
  output reg done
);
  reg [`LATCH_CNT_W-1:0] cnt_q;
  reg run_q;
  // ------------------------------------------------------------
  // count; clear beats start so a new run restarts clean
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= {`LATCH_CNT_W{1'b0}};
      run_q <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        cnt_q <= {`LATCH_CNT_W{1'b0}};
        run_q <= 1'b0;
        done <= 1'b0;
      end else if (start && !run_q && !done) begin
        cnt_q <= {{(`LATCH_CNT_W-1){1'b0}}, 1'b1};
        run_q <= 1'b1;
        if (CYCLES <= {{(`LATCH_CNT_W-1){1'b0}}, 1'b1})
          done <= 1'b1;
      end else if (run_q && !done) begin
        cnt_q <= cnt_q + {{(`LATCH_CNT_W-1){1'b0}}, 1'b1};
        if (cnt_q + {{(`LATCH_CNT_W-1){1'b0}}, 1'b1} >= CYCLES)
          done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: speed_position_changeover_axis.v
// one axis of speed-then-position changeover control
`include "chg_axis_map.vh"
`default_nettype none
module speed_position_changeover_axis #(
  parameter [`LATCH_CNT_W-1:0] LATCH_CYCLES = `LATCH_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  // operation control from the host, the changeover sensor and the pulse stage
  input wire start,
  input wire stop,
  input wire changeover_enable,
  input wire changeover_input,
  input wire [1:0] feed_value_policy,
  input wire [1:0] unit_select,
  input wire [1:0] operation_pattern,
  input wire prev_pattern_cont_path,
  input wire absolute_target_enable,
  input wire [31:0] target_or_distance,
  input wire [31:0] start_feed_value,
  input wire [31:0] stroke_upper,
  input wire [31:0] stroke_lower,
  input wire [31:0] decel_distance,
  input wire accelerating,
  input wire move_pulse,
  input wire move_dir_neg,
  input wire [31:0] move_amount_change_word,
  input wire move_amount_change_write,
  input wire pos_done,
  // status back to the host and the pulse stage
  output reg in_speed_control,
  output wire changeover_latch,
  output reg in_position_control,
  output reg decel_stop,
  output reg busy,
  output reg [31:0] current_feed_value,
  output reg [31:0] position_phase_amount_monitor,
  output reg [31:0] pos_distance,
  output reg [31:0] pos_target,
  output reg absolute_target_mode,
  output reg [15:0] error_code,
  output reg [15:0] warning_code
);
  localparam [2:0] ST_IDLE = `PH_IDLE;
  localparam [2:0] ST_SPEED = `PH_SPEED;
  localparam [2:0] ST_POS = `PH_POS;
  localparam [2:0] ST_DECEL = `PH_DECEL;
  localparam [2:0] ST_DONE = `PH_DONE;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg chg_prev_q;
  reg armed_q;
  reg used_q;
  reg en_prev_q;
  reg enable_ok_q;
  reg [31:0] amount_q;
  reg stroke_err_q;
  reg [15:0] stroke_code_q;
  reg [31:0] travel_q;
  wire chg_level;
  wire chg_rise;
  wire start_ok;
  wire skip_speed;
  wire stroke_check;
  wire [31:0] next_feed;
  wire abs_ok;
  wire short_move;

  // ------------------------------------------------------------
  // input conditioning
  // ------------------------------------------------------------
  chg_input_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin(changeover_input),
    .level(chg_level)
  );

  // single edge per operation, taken whether or not enable is on
  assign chg_rise = chg_level && !chg_prev_q && !used_q;

  // latch flag timer, cleared at every new start
  chg_latch_timer #(
    .CYCLES(LATCH_CYCLES)
  ) u_latch (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .clear(start && !busy),
    .start(chg_rise && armed_q && state_q == ST_SPEED),
    .done(changeover_latch)
  );

  // ------------------------------------------------------------
  // start qualification
  // ------------------------------------------------------------
  // continuous path data cannot start
  assign start_ok = start && !busy &&
    operation_pattern != `PATTERN_CONT_PATH;
  assign skip_speed = changeover_enable && chg_level;
  // absolute mode only in degree with policy 1, enable on and changeover input off at start
  assign abs_ok = absolute_target_enable && unit_select == `UNIT_DEGREE &&
    feed_value_policy == `POLICY_UPDATE && changeover_enable && !chg_level;
  // stroke check only meaningful for linear units with live feed value
  assign stroke_check = feed_value_policy == `POLICY_UPDATE &&
    unit_select != `UNIT_DEGREE;
  // amount too short to hold speed: braking starts at the switch itself,
  // otherwise the axis would overrun the target
  assign short_move = !absolute_target_mode &&
    amount_q < decel_distance;
  assign next_feed = move_dir_neg ? current_feed_value - 32'h00000001 :
    current_feed_value + 32'h00000001;

  // ------------------------------------------------------------
  // phase sequencer
  // ------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_ok && !prev_pattern_cont_path)
          state_d = skip_speed ? ST_POS : ST_SPEED;
        else if (start_ok)
          state_d = ST_DECEL;
      end
      ST_SPEED: begin
        if (stop)
          state_d = ST_DECEL;
        else if (chg_rise && armed_q) begin
          if (stroke_err_q)
            state_d = ST_DECEL;
          else if (short_move)
            state_d = ST_DECEL;
          else
            state_d = ST_POS;
        end
      end
      ST_POS: begin
        if (stop || pos_done)
          state_d = ST_DONE;
      end
      ST_DECEL: begin
        if (pos_done || stop)
          state_d = ST_DONE;
      end
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // state, arming and status flags
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      chg_prev_q <= 1'b0;
      armed_q <= 1'b0;
      used_q <= 1'b0;
      en_prev_q <= 1'b0;
      enable_ok_q <= 1'b0;
      busy <= 1'b0;
      in_speed_control <= 1'b0;
      in_position_control <= 1'b0;
      decel_stop <= 1'b0;
      absolute_target_mode <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      chg_prev_q <= chg_level;
      en_prev_q <= changeover_enable;
      busy <= state_d != ST_IDLE;
      in_speed_control <= state_d == ST_SPEED;
      in_position_control <= state_d == ST_POS;
      decel_stop <= state_d == ST_DECEL;
      if (state_q == ST_IDLE && start_ok) begin
        used_q <= skip_speed;
        // enable must precede the input for a later changeover
        enable_ok_q <= changeover_enable && !chg_level;
        armed_q <= changeover_enable && !chg_level;
        absolute_target_mode <= abs_ok;
      end else if (state_q == ST_SPEED) begin
        // enable rising while input already high disarms
        if (changeover_enable && !en_prev_q && chg_level)
          armed_q <= 1'b0;
        else if (changeover_enable && !chg_level)
          armed_q <= 1'b1;
        else if (!changeover_enable)
          armed_q <= 1'b0;
        if (chg_rise)
          used_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // movement amount handling
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      amount_q <= 32'h00000000;
      pos_distance <= 32'h00000000;
      pos_target <= 32'h00000000;
      position_phase_amount_monitor <= 32'h00000000;
    end else if (ce) begin
      if (state_q == ST_IDLE && start_ok) begin
        amount_q <= target_or_distance;
        if (skip_speed) begin
          pos_distance <= target_or_distance;
          position_phase_amount_monitor <= target_or_distance;
        end
        pos_target <= target_or_distance;
      end else if (state_q == ST_SPEED) begin
        // writes outside the speed phase fall through untouched
        if (move_amount_change_write && !absolute_target_mode)
          amount_q <= move_amount_change_word;
        // a short move brakes at once but still travels the new amount
        if (chg_rise && armed_q && !stop && !stroke_err_q) begin
          pos_distance <= amount_q;
          position_phase_amount_monitor <= amount_q;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // feed value, stroke tracking, errors and warnings
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      current_feed_value <= 32'h00000000;
      travel_q <= 32'h00000000;
      stroke_err_q <= 1'b0;
      stroke_code_q <= `ERR_NONE;
      error_code <= `ERR_NONE;
      warning_code <= `WARN_NONE;
    end else if (ce) begin
      if (state_q == ST_IDLE && start) begin
        stroke_err_q <= 1'b0;
        travel_q <= start_feed_value;
        warning_code <= `WARN_NONE;
        if (!busy && operation_pattern == `PATTERN_CONT_PATH)
          error_code <= `ERR_CONT_PATH;
        else if (!busy && prev_pattern_cont_path)
          error_code <= `ERR_CONT_PATH;
        else
          error_code <= `ERR_NONE;
        if (feed_value_policy == `POLICY_ZERO)
          current_feed_value <= 32'h00000000;
        else
          current_feed_value <= start_feed_value;
      end else if (state_q == ST_SPEED) begin
        if (move_pulse) begin
          travel_q <= move_dir_neg ? travel_q - 32'h00000001 :
            travel_q + 32'h00000001;
          if (feed_value_policy == `POLICY_UPDATE)
            current_feed_value <= next_feed;
        end
        if (stroke_check && !stroke_err_q) begin
          if ($signed(travel_q) > $signed(stroke_upper)) begin
            stroke_err_q <= 1'b1;
            stroke_code_q <= `ERR_STROKE_HI;
          end else if ($signed(travel_q) < $signed(stroke_lower)) begin
            stroke_err_q <= 1'b1;
            stroke_code_q <= `ERR_STROKE_LO;
          end
        end
        if (chg_rise && armed_q) begin
          // error only surfaces at the changeover point
          if (stroke_err_q)
            error_code <= stroke_code_q;
          if (accelerating && !absolute_target_mode)
            warning_code <= `WARN_ACCEL;
        end
      end else if (state_q == ST_POS && move_pulse) begin
        current_feed_value <= next_feed;
      end
    end
  end

endmodule
`default_nettype wire

// File: chg_axis_checker_properties.sv
// concurrent checks on the ports of the changeover axis
`include "chg_axis_map.vh"
`default_nettype none
module chg_axis_checker #(
  parameter [15:0] LATCH_CYCLES = 16'h0004
) (
  input wire logic clk, rst_n, ce, start, changeover_enable,
  input wire logic prev_pattern_cont_path, move_amount_change_write,
  input wire logic [1:0] feed_value_policy, operation_pattern,
  input wire logic in_speed_control, changeover_latch, in_position_control,
  input wire logic decel_stop, busy, absolute_target_mode,
  input wire logic [31:0] current_feed_value, position_phase_amount_monitor,
  input wire logic [31:0] pos_distance, pos_target,
  input wire logic [15:0] error_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // --------------------------------------------------------------
  // phase, refusal and monitor relations
  // --------------------------------------------------------------
  wire take = start && ce && !busy;
  phase_excl_a: assert property (
    !(in_speed_control && in_position_control)) else $error("both phases");
  no_switch_a: assert property (
    in_speed_control && !changeover_enable |=> !in_position_control)
    else $error("switched while disabled");
  speed_hold_a: assert property (
    $fell(in_speed_control) |-> in_position_control || decel_stop || !busy)
    else $error("speed phase dropped");
  freeze_a: assert property (
    in_speed_control && $past(in_speed_control) &&
    feed_value_policy == `POLICY_FREEZE |-> $stable(current_feed_value))
    else $error("feed value moved");
  zero_a: assert property (
    in_speed_control && feed_value_policy == `POLICY_ZERO
    |-> current_feed_value == 32'h0) else $error("feed value not zero");
  latch_time_a: assert property (
    $rose(in_position_control) && $past(in_speed_control)
    |-> ##[1:8] changeover_latch) else $error("latch late");
  late_write_a: assert property (
    in_position_control && move_amount_change_write |=> $stable(pos_distance))
    else $error("late change taken");
  monitor_a: assert property (
    $rose(in_position_control) && $past(in_speed_control) &&
    !absolute_target_mode |-> position_phase_amount_monitor == pos_distance)
    else $error("monitor wrong");
  abs_ignore_a: assert property (
    absolute_target_mode && move_amount_change_write |=> $stable(pos_target))
    else $error("abs target changed");
  cont_refuse_a: assert property (
    take && operation_pattern == `PATTERN_CONT_PATH
    |=> !busy && error_code == `ERR_CONT_PATH) else $error("no refusal");
  prev_cont_a: assert property (
    take && prev_pattern_cont_path && operation_pattern != `PATTERN_CONT_PATH
    |-> ##[1:3] decel_stop && error_code == `ERR_CONT_PATH)
    else $error("no stop after path");
  // main scenarios reached
  sw_c: cover property ($rose(in_position_control));
  ref_c: cover property (take && operation_pattern == `PATTERN_CONT_PATH);
  lat_c: cover property ($rose(changeover_latch));
endmodule
bind speed_position_changeover_axis chg_axis_checker #(
  .LATCH_CYCLES(LATCH_CYCLES)) u_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
  .start(start), .changeover_enable(changeover_enable),
  .prev_pattern_cont_path(prev_pattern_cont_path),
  .move_amount_change_write(move_amount_change_write),
  .feed_value_policy(feed_value_policy),
  .operation_pattern(operation_pattern),
  .in_speed_control(in_speed_control), .changeover_latch(changeover_latch),
  .in_position_control(in_position_control), .decel_stop(decel_stop),
  .busy(busy), .absolute_target_mode(absolute_target_mode),
  .current_feed_value(current_feed_value),
  .position_phase_amount_monitor(position_phase_amount_monitor),
  .pos_distance(pos_distance), .pos_target(pos_target),
  .error_code(error_code));
`default_nettype wire

// File: chg_far_side.sv
// changeover sensor and pulse stage seen from the axis
`default_nettype none
module chg_far_side (
  input wire logic clk,
  input wire logic sense_req,
  input wire logic in_position_control,
  input wire logic decel_stop,
  output var logic changeover_input,
  output var logic pos_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  initial changeover_input = 1'b0;
  initial pos_done = 1'b0;
  // sensor follows the bench, which asks at constant speed and while accelerating
  // finish reported once, long after the switch so the latch is seen
  // pin moves on the rising edge, after the bench has settled the request
  always @(posedge clk) begin
    changeover_input <= sense_req;
  end
  always @(negedge clk) begin
    n <= (in_position_control || decel_stop) ? n + 1 : 0;
    pos_done <= (n == 24);
  end
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the changeover axis
`include "chg_axis_map.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, start, stop, changeover_enable, sense_req, busy;
  logic prev_pattern_cont_path, absolute_target_enable, accelerating;
  logic move_pulse, move_amount_change_write, changeover_input, pos_done;
  logic [1:0] feed_value_policy, unit_select, operation_pattern;
  logic [31:0] target_or_distance, stroke_upper, move_amount_change_word;
  logic in_speed_control, changeover_latch, in_position_control, decel_stop;
  logic absolute_target_mode;
  logic ce;
  logic [31:0] decel_distance;
  logic [31:0] current_feed_value, position_phase_amount_monitor;
  logic [31:0] pos_distance, pos_target;
  logic [15:0] error_code, warning_code;
  logic [31:0] sp [3] = '{32'h100, 32'h103, 32'h0};
  logic [31:0] ps [3] = '{32'h102, 32'h105, 32'h2};
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  int i;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  speed_position_changeover_axis #(.LATCH_CYCLES(16'h0004)) u_dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .start(start), .stop(stop),
    .changeover_enable(changeover_enable), .changeover_input(changeover_input),
    .feed_value_policy(feed_value_policy), .unit_select(unit_select),
    .operation_pattern(operation_pattern),
    .prev_pattern_cont_path(prev_pattern_cont_path),
    .absolute_target_enable(absolute_target_enable),
    .target_or_distance(target_or_distance), .start_feed_value(32'h100),
    .stroke_upper(stroke_upper), .stroke_lower(32'h0),
    .decel_distance(decel_distance), .accelerating(accelerating),
    .move_pulse(move_pulse), .move_dir_neg(1'b0),
    .move_amount_change_word(move_amount_change_word),
    .move_amount_change_write(move_amount_change_write), .pos_done(pos_done),
    .in_speed_control(in_speed_control), .changeover_latch(changeover_latch),
    .in_position_control(in_position_control), .decel_stop(decel_stop),
    .busy(busy), .current_feed_value(current_feed_value),
    .position_phase_amount_monitor(position_phase_amount_monitor),
    .pos_distance(pos_distance), .pos_target(pos_target),
    .absolute_target_mode(absolute_target_mode), .error_code(error_code),
    .warning_code(warning_code));
  chg_far_side u_far (.clk(clk), .sense_req(sense_req),
    .in_position_control(in_position_control), .decel_stop(decel_stop),
    .changeover_input(changeover_input), .pos_done(pos_done));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic go();
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(2);
  endtask
  task automatic steps(input int n);
    repeat (n) begin
      move_pulse = 1'b1;
      tick(1);
      move_pulse = 1'b0;
      tick(1);
    end
  endtask
  task automatic write_word(input logic [31:0] v);
    move_amount_change_word = v;
    move_amount_change_write = 1'b1;
    tick(1);
    move_amount_change_write = 1'b0;
    tick(1);
  endtask
  // sensor on, bounded wait for the switch or a decel stop
  task automatic switch_over();
    sense_req = 1'b1;
    for (i = 0; i < 20 && in_position_control !== 1'b1
         && decel_stop !== 1'b1; i++) tick(1);
  endtask
  // speed phase needs a stop; position phase ends by itself
  task automatic finish_op(input string name);
    if (in_position_control !== 1'b1) stop = 1'b1;
    for (i = 0; i < 100 && busy !== 1'b0; i++) tick(1);
    chk({31'h0, busy}, 32'h0);
    stop = 1'b0;
    sense_req = 1'b0;
    tick(6);
    $display("test %0s done", name);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0; start = 1'b0; stop = 1'b0; sense_req = 1'b0;
    changeover_enable = 1'b1; prev_pattern_cont_path = 1'b0;
    absolute_target_enable = 1'b0; accelerating = 1'b0; move_pulse = 1'b0;
    move_amount_change_write = 1'b0; move_amount_change_word = 32'h0;
    feed_value_policy = 2'h0; unit_select = 2'h0; operation_pattern = 2'h0;
    target_or_distance = 32'h20; stroke_upper = 32'h1000;
    ce = 1'b1;
    decel_distance = 32'h0;
    tick(6);
    rst_n = 1'b1;
    tick(1);
    // frozen block takes no start, so it raises no refusal either
    ce = 1'b0;
    operation_pattern = `PATTERN_CONT_PATH;
    go();
    chk({busy, error_code}, 32'h0);
    ce = 1'b1;
    go();
    chk({busy, error_code}, {1'b0, `ERR_CONT_PATH});
    operation_pattern = 2'h0;
    finish_op("refuse");
    for (int p = 0; p < 3; p++) begin
      feed_value_policy = p[1:0];
      go();
      chk({31'h0, in_speed_control}, 32'h1);
      steps(3);
      chk(current_feed_value, sp[p]);
      write_word(32'h40);
      switch_over();
      chk(pos_distance, 32'h40);
      chk(position_phase_amount_monitor, 32'h40);
      steps(2);
      chk(current_feed_value, ps[p]);
      write_word(32'h77);
      chk(pos_distance, 32'h40);
      tick(4);
      chk({31'h0, changeover_latch}, 32'h1);
      finish_op("policy");
    end
    stroke_upper = 32'h102;
    feed_value_policy = `POLICY_UPDATE;
    for (int u = 0; u < 3; u += 2) begin
      unit_select = u[1:0];
      go();
      steps(3);
      switch_over();
      chk({16'h0, error_code}, u == 0 ? {16'h0, `ERR_STROKE_HI} : 32'h0);
      finish_op("stroke");
    end
    stroke_upper = 32'h1000;
    unit_select = 2'h0;
    accelerating = 1'b1;
    decel_distance = 32'h50;
    go();
    switch_over();
    chk({16'h0, warning_code}, {16'h0, `WARN_ACCEL});
    chk({in_position_control, decel_stop}, 32'h1);
    chk(position_phase_amount_monitor, 32'h20);
    accelerating = 1'b0;
    decel_distance = 32'h0;
    finish_op("accel");
    changeover_enable = 1'b0;
    go();
    sense_req = 1'b1;
    tick(8);
    changeover_enable = 1'b1;
    tick(8);
    chk({in_speed_control, in_position_control}, 32'h2);
    finish_op("late enable");
    sense_req = 1'b1;
    tick(8);
    go();
    chk({in_speed_control, in_position_control}, 32'h1);
    finish_op("both on");
    prev_pattern_cont_path = 1'b1;
    go();
    chk({decel_stop, error_code}, {1'b1, `ERR_CONT_PATH});
    prev_pattern_cont_path = 1'b0;
    finish_op("cont path");
    feed_value_policy = `POLICY_UPDATE;
    unit_select = `UNIT_DEGREE;
    stroke_upper = 32'h0;
    absolute_target_enable = 1'b1;
    target_or_distance = 32'h5a;
    go();
    write_word(32'h33);
    switch_over();
    chk({31'h0, absolute_target_mode}, 32'h1);
    chk(pos_target, 32'h5a);
    finish_op("abs");
    results();
  end
endmodule
`default_nettype wire
